// File: core/oag_core.sv
`timescale 1ns/1ps
// What this block does
// RL1 - Seventeen addressing modes in seven families
// RL2 - Short reaches page zero, long full space
// RL3 - Read-modify-write ops only short forms
// RL4 - Inherent is one byte, no operands
// RL5 - Immediate second byte is the value
// RL6 - Short direct: one address byte
// RL7 - Long direct: two-byte address word
// RL8 - Indexed address is unsigned index plus offset
// RL9 - No-offset indexed uses index register alone
// RL10 - Short indexed adds one byte, up to 1FE
// RL11 - Long indexed adds two-byte offset word
// RL12 - Indirect reads address from pointer location
// RL13 - Short pointer byte, long pointer word
// RL14 - Indirect indexed adds index to pointer
// RL15 - Mask set to level 3, clear to 0
// RL16 - Wait and halt enter low-power modes
// RL17 - Relative adds signed 8-bit offset to PC
// RL18 - PC skips exactly the operand bytes; a long read-modify-write op moves the PC past the opcode only
// RL19 - Short indexed carry kept as ninth bit
module oag_core (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire oag_pkg::oag_instr_t instr_in,
  input wire logic [7:0] x_in,
  input wire logic [7:0] y_in,
  input wire logic [7:0] mem_data_in,
  input wire logic mem_ready_in,
  input wire logic wake_in,
  output logic mem_req_out,
  output logic [15:0] mem_addr_out,
  output logic busy_out,
  output logic done_out,
  output logic illegal_out,
  output oag_pkg::oag_result_t result_out,
  output logic [15:0] pc_out,
  output logic [1:0] irq_level_out,
  output logic wait_mode_out,
  output logic halt_mode_out
);

  typedef enum logic [2:0] {
    OAG_S_IDLE = 3'b000,
    OAG_S_OPND = 3'b001,
    OAG_S_PTR  = 3'b010,
    OAG_S_CALC = 3'b011,
    OAG_S_DONE = 3'b100
  } oag_state_t;

  oag_state_t state_r;
  oag_pkg::oag_instr_t instr_r;
  logic [15:0] pc_r;
  logic [15:0] opnd_r;
  logic [15:0] ptr_r;
  logic [1:0] cnt_r;
  logic [1:0] pcnt_r;
  logic [1:0] op_bytes;
  logic ptr_word;
  logic uses_ptr;
  logic [15:0] idx_base;
  logic [15:0] idx_sum;
  logic [7:0] index_sel;
  logic rmw_long;
  logic [15:0] eff;
  oag_pkg::oag_result_t result_r;
  logic [1:0] irq_level_r;
  logic wait_r;
  logic halt_r;
  logic illegal_r;
  logic take;
  logic opnd_more;
  logic ptr_last;
  logic is_long;
  logic is_rel_i;
  logic [15:0] ptr_addr;
  logic [15:0] rel_off;
  logic set_mask;
  logic clr_mask;
  logic enter_wait;
  logic enter_halt;

  oag_len u_len (
    .mode_in(instr_r.mode),
    .op_bytes_out(op_bytes),
    .ptr_word_out(ptr_word),
    .uses_ptr_out(uses_ptr)
  );

  oag_sum u_sum (
    .base_in(idx_base),
    .index_in(index_sel),
    .sum_out(idx_sum)
  );

  assign index_sel = instr_r.use_y ? y_in : x_in; // RL8

  // Opcode accepted only from idle and outside the low-power modes
  assign take = (state_r == OAG_S_IDLE) && start_in && !wait_r && !halt_r;
  assign opnd_more = (state_r == OAG_S_OPND) && (cnt_r != op_bytes);
  assign ptr_last = (pcnt_r == {1'b0, ptr_word});
  assign is_rel_i = (instr_r.mode == oag_pkg::OAG_REL_I);

  // Long forms cannot carry a read-modify-write op
  always_comb begin
    case (instr_in.mode)
      oag_pkg::OAG_DIR_L, oag_pkg::OAG_IDX_L, oag_pkg::OAG_IND_L,
      oag_pkg::OAG_INDX_L: is_long = 1'b1;
      default: is_long = 1'b0;
    endcase
  end

  assign rmw_long = is_long && instr_in.rmw; // RL3

  always_comb begin
    case (instr_r.mode)
      oag_pkg::OAG_IDX_N: idx_base = 16'h0000; // RL9
      oag_pkg::OAG_IDX_S: idx_base = {8'h00, opnd_r[7:0]}; // RL10
      oag_pkg::OAG_IDX_L: idx_base = opnd_r; // RL11
      oag_pkg::OAG_INDX_S: idx_base = {8'h00, ptr_r[7:0]}; // RL14
      oag_pkg::OAG_INDX_L: idx_base = ptr_r; // RL14
      default: idx_base = 16'h0000;
    endcase
  end

  always_comb begin
    case (instr_r.mode)
      oag_pkg::OAG_DIR_S, oag_pkg::OAG_BIT_D,
      oag_pkg::OAG_BIT_D_REL: eff = {8'h00, opnd_r[7:0]}; // RL2 RL6
      oag_pkg::OAG_DIR_L: eff = opnd_r; // RL7
      oag_pkg::OAG_IDX_N, oag_pkg::OAG_IDX_S, oag_pkg::OAG_IDX_L,
      oag_pkg::OAG_INDX_S, oag_pkg::OAG_INDX_L: eff = idx_sum;
      oag_pkg::OAG_IND_S, oag_pkg::OAG_BIT_I,
      oag_pkg::OAG_BIT_I_REL: eff = {8'h00, ptr_r[7:0]}; // RL13
      oag_pkg::OAG_IND_L: eff = ptr_r; // RL13
      default: eff = 16'h0000;
    endcase
  end

  // Fetch sequencer
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= OAG_S_IDLE;
    end else begin
      case (state_r)
        OAG_S_IDLE: begin
          if (take) begin
            state_r <= rmw_long ? OAG_S_DONE : OAG_S_OPND; // RL3
          end
        end
        OAG_S_OPND: begin
          if (cnt_r == op_bytes) begin
            state_r <= uses_ptr ? OAG_S_PTR : OAG_S_CALC; // RL18
          end
        end
        OAG_S_PTR: begin
          if (mem_ready_in && ptr_last) begin
            state_r <= OAG_S_CALC;
          end
        end
        OAG_S_CALC: begin
          state_r <= OAG_S_DONE;
        end
        OAG_S_DONE: begin
          state_r <= OAG_S_IDLE;
        end
        default: begin
          state_r <= OAG_S_IDLE;
        end
      endcase
    end
  end

  // Mode, index choice and special op are held for the whole instruction
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      instr_r <= '0;
    end else if (take) begin
      instr_r <= instr_in;
    end
  end

  // Flag stays up until the next opcode, so it can still be read after done
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      illegal_r <= 1'b0;
    end else if (take) begin
      illegal_r <= rmw_long; // RL3
    end
  end

  // Operand bytes arrive high byte first
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opnd_r <= 16'h0000;
      cnt_r <= 2'h0;
    end else if (take) begin
      opnd_r <= 16'h0000;
      cnt_r <= 2'h0;
    end else if (opnd_more && mem_ready_in) begin
      opnd_r <= {opnd_r[7:0], mem_data_in};
      cnt_r <= cnt_r + 2'h1; // RL18
    end
  end

  // Pointer bytes, high byte first for a word pointer
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_r <= 16'h0000;
      pcnt_r <= 2'h0;
    end else if (take) begin
      ptr_r <= 16'h0000;
      pcnt_r <= 2'h0;
    end else if (state_r == OAG_S_PTR && mem_ready_in) begin
      ptr_r <= {ptr_r[7:0], mem_data_in}; // RL12
      pcnt_r <= pcnt_r + 2'h1;
    end
  end

  // Program counter: opcode plus exactly the operand bytes consumed
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_r <= oag_pkg::OAG_RESET_PC;
    end else if (take) begin
      pc_r <= pc_r + 16'h0001;
    end else if (opnd_more && mem_ready_in) begin
      pc_r <= pc_r + 16'h0001; // RL18
    end else if (state_r == OAG_S_DONE && result_r.is_branch) begin
      pc_r <= result_r.target; // RL17
    end
  end

  // Pointer lives in page zero; a bit branch keeps its offset in the last byte
  always_comb begin
    ptr_addr = {8'h00, opnd_r[7:0]};
    if (op_bytes == 2'h2) begin
      ptr_addr = {8'h00, opnd_r[15:8]};
    end
  end

  // Memory request: operand bytes from PC, pointer bytes from pointer address
  always_comb begin
    mem_req_out = 1'b0;
    mem_addr_out = pc_r;
    case (state_r)
      OAG_S_OPND: begin
        mem_req_out = opnd_more;
      end
      OAG_S_PTR: begin
        mem_req_out = 1'b1;
        mem_addr_out = ptr_addr + {14'h0000, pcnt_r}; // RL12
      end
      default: begin
        mem_req_out = 1'b0;
      end
    endcase
  end

  // Signed branch offset, from the operand or read through the pointer
  always_comb begin
    rel_off = {{8{opnd_r[7]}}, opnd_r[7:0]};
    if (is_rel_i) begin
      rel_off = {{8{ptr_r[7]}}, ptr_r[7:0]}; // RL17
    end
  end

  // Result assembly
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_r <= '0;
    end else if (state_r == OAG_S_CALC) begin
      result_r.addr <= eff;
      result_r.operand <= opnd_r[7:0]; // RL5
      result_r.is_imm <= (instr_r.mode == oag_pkg::OAG_IMM);
      result_r.is_branch <= is_rel_i ||
        (instr_r.mode == oag_pkg::OAG_REL_D);
      result_r.target <= pc_r + rel_off; // RL17
    end else if (state_r == OAG_S_IDLE && start_in) begin
      result_r <= '0;
    end
  end

  // Special inherent operations act once the instruction reaches CALC
  always_comb begin
    set_mask = 1'b0;
    clr_mask = 1'b0;
    enter_wait = 1'b0;
    enter_halt = 1'b0;
    if (state_r == OAG_S_CALC && instr_r.mode == oag_pkg::OAG_INH) begin
      case (instr_r.special)
        oag_pkg::OAG_OP_SET_IRQ_MASK: set_mask = 1'b1;
        oag_pkg::OAG_OP_CLR_IRQ_MASK: clr_mask = 1'b1;
        oag_pkg::OAG_OP_WAIT_FOR_IRQ: enter_wait = 1'b1;
        oag_pkg::OAG_OP_HALT: enter_halt = 1'b1;
        default: set_mask = 1'b0;
      endcase
    end
  end

  // Interrupt mask level; starts masked as after a core reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_level_r <= oag_pkg::OAG_IRQ_LEVEL_RESET;
    end else if (set_mask) begin
      irq_level_r <= oag_pkg::OAG_IRQ_LEVEL_MAX; // RL15
    end else if (clr_mask) begin
      irq_level_r <= oag_pkg::OAG_IRQ_LEVEL_MIN; // RL15
    end
  end

  // Wake wins over entry, so an interrupt that meets the op is not lost
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_r <= 1'b0;
    end else if (wake_in) begin
      wait_r <= 1'b0;
    end else if (enter_wait) begin
      wait_r <= 1'b1; // RL16
    end
  end

  // Same priority for halt; only a wake request or a reset restarts the core
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      halt_r <= 1'b0;
    end else if (wake_in) begin
      halt_r <= 1'b0;
    end else if (enter_halt) begin
      halt_r <= 1'b1; // RL16
    end
  end

  assign busy_out = (state_r != OAG_S_IDLE);
  assign done_out = (state_r == OAG_S_DONE);
  assign illegal_out = illegal_r;
  assign result_out = result_r;
  assign pc_out = pc_r;
  assign irq_level_out = irq_level_r;
  assign wait_mode_out = wait_r;
  assign halt_mode_out = halt_r;

endmodule : oag_core

// File: common/oag_pkg.sv
package oag_pkg;

  // Seventeen addressing modes in seven families
  typedef enum logic [4:0] {
    OAG_INH       = 5'h00,
    OAG_IMM       = 5'h01,
    OAG_DIR_S     = 5'h02,
    OAG_DIR_L     = 5'h03,
    OAG_IDX_N     = 5'h04,
    OAG_IDX_S     = 5'h05,
    OAG_IDX_L     = 5'h06,
    OAG_IND_S     = 5'h07,
    OAG_IND_L     = 5'h08,
    OAG_INDX_S    = 5'h09,
    OAG_INDX_L    = 5'h0A,
    OAG_REL_D     = 5'h0B,
    OAG_REL_I     = 5'h0C,
    OAG_BIT_D     = 5'h0D,
    OAG_BIT_I     = 5'h0E,
    OAG_BIT_D_REL = 5'h0F,
    OAG_BIT_I_REL = 5'h10
  } oag_mode_t;

  // Inherent special operations
  typedef enum logic [2:0] {
    OAG_OP_NONE          = 3'h0,
    OAG_OP_SET_IRQ_MASK  = 3'h1,
    OAG_OP_CLR_IRQ_MASK  = 3'h2,
    OAG_OP_WAIT_FOR_IRQ  = 3'h3,
    OAG_OP_HALT          = 3'h4
  } oag_special_t;

  typedef struct packed {
    oag_mode_t mode;
    logic use_y;
    logic rmw;
    oag_special_t special;
  } oag_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] operand;
    logic is_imm;
    logic is_branch;
    logic [15:0] target;
  } oag_result_t;

  localparam logic [1:0] OAG_IRQ_LEVEL_MAX = 2'h3;
  localparam logic [1:0] OAG_IRQ_LEVEL_MIN = 2'h0;
  localparam logic [15:0] OAG_RESET_PC = 16'h0000;
  localparam logic [15:0] OAG_PAGE0_MASK = 16'h00FF;
  localparam logic [1:0] OAG_IRQ_LEVEL_RESET = 2'h3;

endpackage : oag_pkg

// File: core/oag_len.sv
`timescale 1ns/1ps
// Operand byte count per mode, and the pointer fetch size
module oag_len (
  input wire oag_pkg::oag_mode_t mode_in,
  output logic [1:0] op_bytes_out,
  output logic ptr_word_out,
  output logic uses_ptr_out
);
  always_comb begin
    op_bytes_out = 2'h0;
    ptr_word_out = 1'b0;
    uses_ptr_out = 1'b0;
    case (mode_in) // RL1
      oag_pkg::OAG_INH, oag_pkg::OAG_IDX_N: op_bytes_out = 2'h0; // RL4 RL9
      oag_pkg::OAG_IMM, oag_pkg::OAG_DIR_S, oag_pkg::OAG_IDX_S,
      oag_pkg::OAG_REL_D, oag_pkg::OAG_BIT_D: op_bytes_out = 2'h1; // RL5 RL6 RL10
      oag_pkg::OAG_DIR_L, oag_pkg::OAG_IDX_L,
      oag_pkg::OAG_BIT_D_REL: op_bytes_out = 2'h2; // RL7 RL11
      oag_pkg::OAG_IND_S, oag_pkg::OAG_INDX_S, oag_pkg::OAG_REL_I,
      oag_pkg::OAG_BIT_I: begin
        op_bytes_out = 2'h1;
        uses_ptr_out = 1'b1; // RL12
      end
      oag_pkg::OAG_BIT_I_REL: begin
        op_bytes_out = 2'h2;
        uses_ptr_out = 1'b1;
      end
      oag_pkg::OAG_IND_L, oag_pkg::OAG_INDX_L: begin
        op_bytes_out = 2'h1;
        uses_ptr_out = 1'b1;
        ptr_word_out = 1'b1; // RL13
      end
      default: op_bytes_out = 2'h0;
    endcase
  end
endmodule : oag_len

// File: core/oag_sum.sv
`timescale 1ns/1ps
// Unsigned index plus base; short forms keep the ninth bit
module oag_sum (
  input wire logic [15:0] base_in,
  input wire logic [7:0] index_in,
  output logic [15:0] sum_out
);
  assign sum_out = base_in + {8'h00, index_in}; // RL8 RL19
endmodule : oag_sum

// File: testbench/oag_assertions.sv
`timescale 1ns/1ps
module oag_assertions (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic wake_in,
  input wire logic mem_req_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic illegal_out,
  input wire oag_pkg::oag_result_t result_out,
  input wire logic [15:0] pc_out,
  input wire logic [1:0] irq_level_out,
  input wire logic wait_mode_out,
  input wire logic halt_mode_out
);
  logic take;
  logic sleep;
  assign take = start_in && !busy_out && !wait_mode_out && !halt_mode_out;
  assign sleep = wait_mode_out || halt_mode_out;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_done_pulse: assert property (done_out |=> !done_out)
    else $error("done wider than one cycle");
  chk_take_busy: assert property (take |=> busy_out)
    else $error("start not taken");
  chk_take_pc: assert property (take |=> pc_out == $past(pc_out) + 16'h1)
    else $error("opcode byte not counted");
  chk_idle_pc: assert property (!busy_out && !take |=> $stable(pc_out))
    else $error("pc moved while idle");
  chk_done_bound: assert property (take |-> ##[1:40] done_out)
    else $error("no done after start");
  chk_idle_noreq: assert property (!busy_out |-> !mem_req_out)
    else $error("fetch while idle");
  chk_mask_level: assert property (irq_level_out inside {2'h0, 2'h3})
    else $error("mask level neither 0 nor 3");
  chk_sleep_refuse: assert property (sleep && !busy_out |=> !busy_out)
    else $error("start taken in low power");
  chk_wake_exit: assert property (sleep && wake_in |=> !sleep)
    else $error("wake ignored");
  chk_branch_pc: assert property (done_out && result_out.is_branch |=>
    pc_out == result_out.target)
    else $error("branch target not loaded");
  chk_illegal_zero: assert property (done_out && illegal_out |-> result_out == '0)
    else $error("illegal result not zero");
  cover property (done_out && illegal_out);
  cover property ($rose(halt_mode_out));
  cover property (done_out && result_out.is_branch);
endmodule : oag_assertions

// File: testbench/oag_mem_model.sv
`timescale 1ns/1ps
module oag_mem_model (
  input wire logic clock_in,
  input wire logic req_in,
  input wire logic [15:0] addr_in,
  input wire logic [1:0] lat_in,
  output logic [7:0] data_out,
  output logic ready_out
);
  logic [7:0] bytes [0:65535];
  logic [1:0] wait_r;
  initial begin
    data_out = 8'h5A;
    ready_out = 1'b0;
    wait_r = 2'h0;
  end
  // Idle data toggles every cycle so a stale byte never looks valid
  always @(negedge clock_in) begin
    if (req_in && wait_r >= lat_in) begin
      ready_out <= 1'b1;
      data_out <= bytes[addr_in];
      wait_r <= 2'h0;
    end else begin
      ready_out <= 1'b0;
      data_out <= ~data_out;
      wait_r <= req_in ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule : oag_mem_model

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock_in, rst_n_in, start_in, wake_in, req, rdy, busy, done, illegal, wt, hlt;
  logic [7:0] xv, yv, rdata;
  logic [1:0] lat, irq;
  logic [15:0] maddr, pc, pc_e;
  oag_pkg::oag_instr_t ins;
  oag_pkg::oag_result_t res;
  int n_fail, n_checks;
  oag_core dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_in),
    .instr_in(ins), .x_in(xv), .y_in(yv), .mem_data_in(rdata), .mem_ready_in(rdy),
    .wake_in(wake_in), .mem_req_out(req), .mem_addr_out(maddr), .busy_out(busy),
    .done_out(done), .illegal_out(illegal), .result_out(res), .pc_out(pc),
    .irq_level_out(irq), .wait_mode_out(wt), .halt_mode_out(hlt));
  oag_mem_model mem (.clock_in(clock_in), .req_in(req), .addr_in(maddr), .lat_in(lat),
    .data_out(rdata), .ready_out(rdy));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic op(input oag_pkg::oag_mode_t m, input logic [7:0] b0, b1, input int n);
    int k;
    while (busy !== 1'b0) @(negedge clock_in);
    mem.bytes[pc_e + 16'h1] = b0;
    mem.bytes[pc_e + 16'h2] = b1;
    ins.mode = m;
    start_in = 1'b1;
    @(negedge clock_in);
    start_in = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 50) begin
      @(negedge clock_in);
      k++;
    end
    check(16'(k < 50), 16'h1);
    pc_e = pc_e + 16'(1 + n);
  endtask : op
  task automatic wake();
    wake_in = 1'b1;
    @(negedge clock_in);
    wake_in = 1'b0;
    @(negedge clock_in);
  endtask : wake
  task automatic s_plain();
    op(oag_pkg::OAG_INH, 8'h00, 8'h00, 0);
    check(pc, pc_e);
    op(oag_pkg::OAG_IMM, 8'hA5, 8'h00, 1);
    check({res.operand, 7'h0, res.is_imm}, 16'hA501);
    op(oag_pkg::OAG_DIR_S, 8'hC3, 8'h00, 1);
    check(res.addr, 16'h00C3);
    lat = 2'h2;
    op(oag_pkg::OAG_DIR_L, 8'h12, 8'h34, 2);
    check(res.addr, 16'h1234);
    check(pc, pc_e);
    lat = 2'h0;
  endtask : s_plain
  task automatic s_index();
    xv = 8'hF0;
    op(oag_pkg::OAG_IDX_N, 8'h00, 8'h00, 0);
    check(res.addr, 16'h00F0);
    op(oag_pkg::OAG_IDX_S, 8'h10, 8'h00, 1);
    check(res.addr, 16'h0100);
    ins.use_y = 1'b1;
    yv = 8'hFF;
    op(oag_pkg::OAG_IDX_S, 8'hFF, 8'h00, 1);
    check(res.addr, 16'h01FE);
    op(oag_pkg::OAG_IDX_L, 8'hFF, 8'h00, 2);
    check(res.addr, 16'hFFFF);
    check(pc, pc_e);
    ins.use_y = 1'b0;
  endtask : s_index
  task automatic s_indirect();
    mem.bytes[16'h0090] = 8'hAB;
    mem.bytes[16'h0091] = 8'hCD;
    op(oag_pkg::OAG_IND_S, 8'h90, 8'h00, 1);
    check(res.addr, 16'h00AB);
    lat = 2'h1;
    op(oag_pkg::OAG_IND_L, 8'h90, 8'h00, 1);
    check(res.addr, 16'hABCD);
    xv = 8'h60;
    op(oag_pkg::OAG_INDX_S, 8'h90, 8'h00, 1);
    check(res.addr, 16'h010B);
    op(oag_pkg::OAG_INDX_L, 8'h90, 8'h00, 1);
    check(res.addr, 16'hAC2D);
    op(oag_pkg::OAG_BIT_I_REL, 8'h90, 8'h07, 2);
    check(res.addr, 16'h00AB);
    op(oag_pkg::OAG_BIT_D, 8'h33, 8'h00, 1);
    check(res.addr, 16'h0033);
    check(pc, pc_e);
    lat = 2'h0;
  endtask : s_indirect
  task automatic s_branch();
    logic [15:0] p;
    p = pc_e;
    op(oag_pkg::OAG_REL_D, 8'hFE, 8'h00, 1);
    check(res.target, p);
    @(negedge clock_in);
    check(pc, p);
    pc_e = p;
    mem.bytes[16'h0092] = 8'h04;
    op(oag_pkg::OAG_REL_I, 8'h92, 8'h00, 1);
    check(res.target, p + 16'h0006);
    @(negedge clock_in);
    check(pc, p + 16'h0006);
    pc_e = p + 16'h0006;
  endtask : s_branch
  task automatic s_power();
    ins.special = oag_pkg::OAG_OP_CLR_IRQ_MASK;
    op(oag_pkg::OAG_INH, 8'h00, 8'h00, 0);
    check(16'(irq), 16'h0);
    ins.special = oag_pkg::OAG_OP_SET_IRQ_MASK;
    op(oag_pkg::OAG_INH, 8'h00, 8'h00, 0);
    check(16'(irq), 16'h3);
    ins.special = oag_pkg::OAG_OP_WAIT_FOR_IRQ;
    op(oag_pkg::OAG_INH, 8'h00, 8'h00, 0);
    start_in = 1'b1;
    repeat (3) @(negedge clock_in);
    check({7'h0, wt, 7'h0, busy}, 16'h0100);
    start_in = 1'b0;
    wake();
    check(16'(wt), 16'h0);
    ins.special = oag_pkg::OAG_OP_HALT;
    op(oag_pkg::OAG_INH, 8'h00, 8'h00, 0);
    check(16'(hlt), 16'h1);
    wake();
    check(16'({hlt, wt}), 16'h0000);
    check(pc, pc_e);
    ins.special = oag_pkg::OAG_OP_NONE;
  endtask : s_power
  task automatic s_rmw();
    ins.rmw = 1'b1;
    op(oag_pkg::OAG_DIR_S, 8'h42, 8'h00, 1);
    check({illegal, res.addr[14:0]}, 16'h0042);
    op(oag_pkg::OAG_DIR_L, 8'h12, 8'h34, 0);
    check({illegal, res.addr[14:0]}, 16'h8000);
    check(pc, pc_e);
    ins.rmw = 1'b0;
  endtask : s_rmw
  task automatic s_reset();
    ins.special = oag_pkg::OAG_OP_CLR_IRQ_MASK;
    op(oag_pkg::OAG_INH, 8'h00, 8'h00, 0);
    ins.special = oag_pkg::OAG_OP_NONE;
    rst_n_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rst_n_in = 1'b1;
    check(16'(irq), 16'h3);
    check(pc, oag_pkg::OAG_RESET_PC);
    pc_e = oag_pkg::OAG_RESET_PC;
    op(oag_pkg::OAG_DIR_S, 8'h5C, 8'h00, 1);
    check(res.addr, 16'h005C);
    check(pc, pc_e);
  endtask : s_reset
  initial begin
    rst_n_in = 1'b0;
    start_in = 1'b0;
    wake_in = 1'b0;
    ins = '0;
    xv = 8'h00;
    yv = 8'h00;
    lat = 2'h0;
    pc_e = 16'h0000;
    n_fail = 0;
    n_checks = 0;
    repeat (8) @(negedge clock_in);
    rst_n_in = 1'b1;
    check(16'(irq), 16'h3);
    s_plain();
    s_index();
    s_indirect();
    s_branch();
    s_power();
    s_rmw();
    s_reset();
    conclude();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
endmodule : tb_top
bind oag_core oag_assertions chk_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .start_in(start_in), .wake_in(wake_in), .mem_req_out(mem_req_out), .busy_out(busy_out),
  .done_out(done_out), .illegal_out(illegal_out), .result_out(result_out), .pc_out(pc_out),
  .irq_level_out(irq_level_out), .wait_mode_out(wait_mode_out),
  .halt_mode_out(halt_mode_out));
